// File: cpt_defs.vh
// cpt_defs.vh - constants of the cascaded pulse and warm-up timer
// assumes: included by bare name from every design file of the block
`ifndef CPT_DEFS_VH
`define CPT_DEFS_VH

// register byte offsets
`define CPT_OFS_LOW_CTRL 8'h00
`define CPT_OFS_HIGH_CTRL 8'h04
`define CPT_OFS_PERIOD_LO 8'h08
`define CPT_OFS_PERIOD_HI 8'h0C
`define CPT_OFS_WIDTH_LO 8'h10
`define CPT_OFS_WIDTH_HI 8'h14
`define CPT_OFS_STATUS 8'h18

// reset values
`define CPT_RST_BYTE 8'h00
`define CPT_RST_COUNT 16'h0000

// low_counter_control fields
`define CPT_SRC_MSB 6
`define CPT_SRC_LSB 4

// high_counter_control fields
`define CPT_FLOP_INIT_BIT 7
`define CPT_RUN_BIT 3
`define CPT_MODE_MSB 2
`define CPT_MODE_LSB 0
`define CPT_MODE_PULSE 3'h7
`define CPT_MODE_WARMUP 3'h5

// source select codes
`define CPT_SRC_DIV2048 3'h0
`define CPT_SRC_DIV128 3'h1
`define CPT_SRC_DIV32 3'h2
`define CPT_SRC_DIV8 3'h3
`define CPT_SRC_SLOW 3'h4
`define CPT_SRC_DIV2 3'h5
`define CPT_SRC_FULL 3'h6
`define CPT_SRC_EXT 3'h7

// prescaler width and divider exponents
`define CPT_DIV_W 11
`define CPT_EXP_2048 4'hB
`define CPT_EXP_128 4'h7
`define CPT_EXP_32 4'h5
`define CPT_EXP_8 4'h3
`define CPT_EXP_2 4'h1

// external input timing: one machine cycle in core clocks, two needed
`define CPT_MACH_CYC_CLK 4
`define CPT_EXT_MIN_MACH 2
`define CPT_EXT_MIN_CLK (`CPT_MACH_CYC_CLK * `CPT_EXT_MIN_MACH)
`define CPT_EXT_CNT_W 4

// ahb encodings
`define CPT_HTRANS_NONSEQ 2'h2
`define CPT_HTRANS_SEQ 2'h3
`define CPT_HRESP_OKAY 1'b0

`endif

// File: cpt_ext_filter.v
// cpt_ext_filter.v - qualifies the external count input
// assumes: input synchronous to core clock; counts on accepted falling edge
`timescale 1ns/1ps
`default_nettype none
`include "cpt_defs.vh"

module cpt_ext_filter (
   input wire core_clk_in, // core clock
   input wire rst_in, // sync reset, high
   input wire ext_in, // external count level
   output reg fall_out // one-cycle accepted falling edge
);

   reg raw_r;
   reg level_r;
   reg [`CPT_EXT_CNT_W-1:0] stable_r;

   ////////////////////////////////////////////////////////////////////////
   // a level counts only once it held two machine cycles
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         raw_r <= 1'b1;
         level_r <= 1'b1;
         stable_r <= {`CPT_EXT_CNT_W{1'b0}};
         fall_out <= 1'b0;
      end else begin
         raw_r <= ext_in;
         fall_out <= 1'b0;
         if (ext_in != raw_r) begin
            stable_r <= {{(`CPT_EXT_CNT_W-1){1'b0}}, 1'b1};
         end else if (stable_r != `CPT_EXT_MIN_CLK) begin
            stable_r <= stable_r + 1'b1;
         end
         if (ext_in == raw_r && stable_r == `CPT_EXT_MIN_CLK - 1 && raw_r != level_r) begin
            level_r <= raw_r;
            fall_out <= ~raw_r;
         end
      end
   end

endmodule // cpt_ext_filter
`default_nettype wire

// File: cpt_prescale.v
// cpt_prescale.v - free-running divider and count source select
// assumes: slow_tick_in is a one-cycle pulse at the low-frequency rate
`timescale 1ns/1ps
`default_nettype none
`include "cpt_defs.vh"

module cpt_prescale (
   input wire core_clk_in, // core clock
   input wire rst_in, // sync reset, high
   input wire [2:0] src_in, // low_counter_source_select
   input wire slow_tick_in, // low-frequency tick
   input wire ext_fall_in, // qualified external edge
   output wire tick_out // one-cycle count tick
);

   reg [`CPT_DIV_W-1:0] div_r;
   reg tick_sel;

   // high when the low n divider bits are all ones
   function div_hit;
      input [`CPT_DIV_W-1:0] div;
      input [3:0] n;
      integer i;
      begin
         div_hit = 1'b1;
         for (i = 0; i < `CPT_DIV_W; i = i + 1) begin
            if (i < n && !div[i]) div_hit = 1'b0;
         end
      end
   endfunction

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         div_r <= {`CPT_DIV_W{1'b0}};
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // internal or external source
   always @* begin
      case (src_in)
         `CPT_SRC_DIV2048: tick_sel = div_hit(div_r, `CPT_EXP_2048);
         `CPT_SRC_DIV128: tick_sel = div_hit(div_r, `CPT_EXP_128);
         `CPT_SRC_DIV32: tick_sel = div_hit(div_r, `CPT_EXP_32);
         `CPT_SRC_DIV8: tick_sel = div_hit(div_r, `CPT_EXP_8);
         `CPT_SRC_SLOW: tick_sel = slow_tick_in;
         `CPT_SRC_DIV2: tick_sel = div_hit(div_r, `CPT_EXP_2);
         `CPT_SRC_FULL: tick_sel = 1'b1;
         `CPT_SRC_EXT: tick_sel = ext_fall_in;
         default: tick_sel = 1'b0;
      endcase
   end

   assign tick_out = tick_sel;

endmodule // cpt_prescale
`default_nettype wire

// File: cpt_timer.v
// cpt_timer.v - cascaded 16-bit pulse generator and warm-up timer, ahb-lite slave
// assumes: single ahb-lite master, word transfers, all inputs synchronous to core_clk_in
`timescale 1ns/1ps
`default_nettype none
`include "cpt_defs.vh"

module cpt_timer (
   input wire core_clk_in, // 250 MHz core clock
   input wire rst_in, // sync reset, high
   input wire hsel_in, // ahb slave select
   input wire [31:0] haddr_in, // ahb address
   input wire [1:0] htrans_in, // ahb transfer type
   input wire hwrite_in, // ahb write
   input wire [2:0] hsize_in, // ahb size, word only
   input wire [31:0] hwdata_in, // ahb write data
   input wire hready_in, // ahb bus ready
   output reg hreadyout_out, // ahb slave ready
   output reg hresp_out, // ahb response, always okay
   output reg [31:0] hrdata_out, // ahb read data
   input wire slow_tick_in, // low-frequency clock tick pulse
   input wire external_count_input_in, // external count input
   output reg timer_output_pin_out, // pulse output, inverse of flop
   output reg cascade_timer_irq_out // one-cycle period match pulse
);

   reg [7:0] low_counter_control_r;
   reg [7:0] high_counter_control_r;
   reg [7:0] period_low_byte_r;
   reg [7:0] period_high_byte_r;
   reg [7:0] width_low_byte_r;
   reg [7:0] width_high_byte_r;
   reg [7:0] low_counter_control_nxt;
   reg [7:0] high_counter_control_nxt;
   reg [7:0] period_low_byte_nxt;
   reg [7:0] period_high_byte_nxt;
   reg [7:0] width_low_byte_nxt;
   reg [7:0] width_high_byte_nxt;
   reg [15:0] count_r;
   reg [15:0] count_nxt;
   reg output_toggle_flop_r;
   reg output_toggle_flop_nxt;
   reg irq_nxt;
   reg wr_pend_r;
   reg [7:0] wr_addr_r;
   reg [31:0] rdata_nxt;
   wire ext_fall;
   wire src_tick;
   wire addr_take;
   wire [15:0] count_inc;
   wire [15:0] period_val;
   wire [15:0] width_val;
   wire [2:0] mode;
   wire run;
   wire pulse_mode;
   wire warm_mode;
   wire period_hit;
   wire width_hit;

   ////////////////////////////////////////////////////////////////////////
   // count source
   cpt_ext_filter u_ext (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .ext_in(external_count_input_in),
      .fall_out(ext_fall)
   );

   cpt_prescale u_pre (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .src_in(low_counter_control_r[`CPT_SRC_MSB:`CPT_SRC_LSB]),
      .slow_tick_in(slow_tick_in),
      .ext_fall_in(ext_fall),
      .tick_out(src_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // ahb address phase
   assign addr_take = hsel_in && hready_in &&
      (htrans_in == `CPT_HTRANS_NONSEQ || htrans_in == `CPT_HTRANS_SEQ);

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= addr_take && hwrite_in;
         if (addr_take) begin
            wr_addr_r <= haddr_in[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register writes in data phase
   always @* begin
      low_counter_control_nxt = low_counter_control_r;
      high_counter_control_nxt = high_counter_control_r;
      period_low_byte_nxt = period_low_byte_r;
      period_high_byte_nxt = period_high_byte_r;
      width_low_byte_nxt = width_low_byte_r;
      width_high_byte_nxt = width_high_byte_r;
      if (wr_pend_r) begin
         case (wr_addr_r)
            `CPT_OFS_LOW_CTRL: low_counter_control_nxt = hwdata_in[7:0];
            `CPT_OFS_HIGH_CTRL: high_counter_control_nxt = hwdata_in[7:0];
            `CPT_OFS_PERIOD_LO: period_low_byte_nxt = hwdata_in[7:0];
            `CPT_OFS_PERIOD_HI: period_high_byte_nxt = hwdata_in[7:0];
            `CPT_OFS_WIDTH_LO: width_low_byte_nxt = hwdata_in[7:0];
            `CPT_OFS_WIDTH_HI: width_high_byte_nxt = hwdata_in[7:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counter and match logic
   assign mode = high_counter_control_r[`CPT_MODE_MSB:`CPT_MODE_LSB];
   assign run = high_counter_control_r[`CPT_RUN_BIT];
   assign pulse_mode = (mode == `CPT_MODE_PULSE);
   assign warm_mode = (mode == `CPT_MODE_WARMUP);
   assign period_val = {period_high_byte_r, period_low_byte_r};
   assign width_val = {width_high_byte_r, width_low_byte_r};
   assign count_inc = count_r + 16'h0001;
   // warm-up ignores the period low byte
   assign period_hit = warm_mode ? (count_inc == {period_high_byte_r, 8'h00}) :
      (count_inc == period_val);
   assign width_hit = (count_inc == width_val);

   always @* begin
      count_nxt = count_r;
      output_toggle_flop_nxt = output_toggle_flop_r;
      irq_nxt = 1'b0;
      if (!run) begin
         count_nxt = `CPT_RST_COUNT;
         // stop alone leaves the flop alone
         if (wr_pend_r && wr_addr_r == `CPT_OFS_HIGH_CTRL && !run) begin
            output_toggle_flop_nxt = hwdata_in[`CPT_FLOP_INIT_BIT];
         end
      end else if (src_tick && (pulse_mode || warm_mode)) begin
         count_nxt = count_inc;
         if (period_hit) begin
            count_nxt = `CPT_RST_COUNT;
            irq_nxt = 1'b1;
            if (pulse_mode) begin
               output_toggle_flop_nxt = ~output_toggle_flop_r;
            end
         end else if (width_hit && pulse_mode) begin
            output_toggle_flop_nxt = ~output_toggle_flop_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux, sees this cycle's writes
   always @* begin
      rdata_nxt = 32'h00000000;
      case (haddr_in[7:0])
         `CPT_OFS_LOW_CTRL: rdata_nxt[7:0] = low_counter_control_nxt;
         `CPT_OFS_HIGH_CTRL: rdata_nxt[7:0] = high_counter_control_nxt;
         `CPT_OFS_PERIOD_LO: rdata_nxt[7:0] = period_low_byte_nxt;
         `CPT_OFS_PERIOD_HI: rdata_nxt[7:0] = period_high_byte_nxt;
         `CPT_OFS_WIDTH_LO: rdata_nxt[7:0] = width_low_byte_nxt;
         `CPT_OFS_WIDTH_HI: rdata_nxt[7:0] = width_high_byte_nxt;
         `CPT_OFS_STATUS: rdata_nxt[16:0] = {output_toggle_flop_nxt, count_nxt};
         default: rdata_nxt = 32'h00000000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state registers
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         low_counter_control_r <= `CPT_RST_BYTE;
         high_counter_control_r <= `CPT_RST_BYTE;
         period_low_byte_r <= `CPT_RST_BYTE;
         period_high_byte_r <= `CPT_RST_BYTE;
         width_low_byte_r <= `CPT_RST_BYTE;
         width_high_byte_r <= `CPT_RST_BYTE;
         count_r <= `CPT_RST_COUNT;
         output_toggle_flop_r <= 1'b0;
         timer_output_pin_out <= 1'b1;
         cascade_timer_irq_out <= 1'b0;
         hreadyout_out <= 1'b1;
         hresp_out <= `CPT_HRESP_OKAY;
         hrdata_out <= 32'h00000000;
      end else begin
         low_counter_control_r <= low_counter_control_nxt;
         high_counter_control_r <= high_counter_control_nxt;
         period_low_byte_r <= period_low_byte_nxt;
         period_high_byte_r <= period_high_byte_nxt;
         width_low_byte_r <= width_low_byte_nxt;
         width_high_byte_r <= width_high_byte_nxt;
         count_r <= count_nxt;
         output_toggle_flop_r <= output_toggle_flop_nxt;
         timer_output_pin_out <= ~output_toggle_flop_nxt;
         cascade_timer_irq_out <= irq_nxt;
         hreadyout_out <= 1'b1;
         hresp_out <= `CPT_HRESP_OKAY;
         if (addr_take && !hwrite_in) begin
            hrdata_out <= rdata_nxt;
         end
      end
   end

endmodule // cpt_timer
`default_nettype wire

// File: cpt_timer_checker.sv
// cpt_timer_checker.sv - port-level assertions for cpt_timer
// assumes: bound into cpt_timer; hready_in follows hreadyout_out
`timescale 1ns/1ps
`default_nettype none
`include "cpt_defs.vh"

module cpt_timer_checker (
   input wire logic core_clk_in, // core clock
   input wire logic rst_in, // sync reset, high
   input wire logic hsel_in, // ahb select
   input wire logic [31:0] haddr_in, // ahb address
   input wire logic [1:0] htrans_in, // ahb transfer type
   input wire logic hwrite_in, // ahb write
   input wire logic [31:0] hwdata_in, // ahb write data
   input wire logic hready_in, // ahb bus ready
   input wire logic hreadyout_out, // ahb slave ready
   input wire logic hresp_out, // ahb response
   input wire logic [31:0] hrdata_out, // ahb read data
   input wire logic timer_output_pin_out, // pulse output
   input wire logic cascade_timer_irq_out // period match pulse
);
   logic take;
   logic rd_take;
   logic ctl_wr;
   logic quiet;
   logic wr_q;
   logic ctl_q1;
   logic ctl_q2;
   logic run_r;
   logic pulse_r;
   logic warm_r;
   logic [7:0] a_q;
   assign take = hsel_in && hready_in && htrans_in[1];
   assign rd_take = take && !hwrite_in;
   assign ctl_wr = wr_q && (a_q == `CPT_OFS_HIGH_CTRL);
   assign quiet = !ctl_wr && !ctl_q1 && !ctl_q2;
   ////////////////////////////////////////////////////////////////
   // mirror of run and mode bits from bus writes
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         wr_q <= 1'b0;
         a_q <= 8'h00;
         ctl_q1 <= 1'b0;
         ctl_q2 <= 1'b0;
         run_r <= 1'b0;
         pulse_r <= 1'b0;
         warm_r <= 1'b0;
      end else begin
         wr_q <= take && hwrite_in;
         a_q <= haddr_in[7:0];
         ctl_q1 <= ctl_wr;
         ctl_q2 <= ctl_q1;
         if (ctl_wr) begin
            run_r <= hwdata_in[`CPT_RUN_BIT];
            pulse_r <= hwdata_in[2:0] == `CPT_MODE_PULSE;
            warm_r <= hwdata_in[2:0] == `CPT_MODE_WARMUP;
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   sequence s_status_rd;
      rd_take && (haddr_in[7:0] == `CPT_OFS_STATUS);
   endsequence
   sequence s_irq_pulse;
      cascade_timer_irq_out ##1 !cascade_timer_irq_out;
   endsequence
   a_reset_levels: assert property ($fell(rst_in) |-> timer_output_pin_out && !cascade_timer_irq_out)
      else $error("pin or irq wrong after reset");
   a_stop_holds_pin: assert property (!run_r && quiet |=> $stable(timer_output_pin_out))
      else $error("pin moved while stopped");
   a_warm_no_pulse: assert property (warm_r && quiet |=> $stable(timer_output_pin_out))
      else $error("pin moved in warm-up mode");
   a_period_toggle: assert property (cascade_timer_irq_out && pulse_r |-> $changed(timer_output_pin_out))
      else $error("no toggle with period match");
   a_irq_needs_run: assert property (cascade_timer_irq_out |-> $past(run_r))
      else $error("irq without run");
   a_irq_single: assert property (cascade_timer_irq_out |-> s_irq_pulse)
      else $error("irq longer than one cycle");
   a_flop_status: assert property (s_status_rd |=> hrdata_out[16] != timer_output_pin_out)
      else $error("pin not inverse of flop");
   a_read_hold: assert property (!rd_take |=> $stable(hrdata_out))
      else $error("read data changed without read");
   a_bus_okay: assert property (hreadyout_out && !hresp_out)
      else $error("bus not ready or not okay");
endmodule // cpt_timer_checker

bind cpt_timer cpt_timer_checker u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
   .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
   .hwdata_in(hwdata_in), .hready_in(hready_in), .hreadyout_out(hreadyout_out),
   .hresp_out(hresp_out), .hrdata_out(hrdata_out),
   .timer_output_pin_out(timer_output_pin_out),
   .cascade_timer_irq_out(cascade_timer_irq_out));
`default_nettype wire

// File: testbench.sv
// testbench.sv - self-checking bench for cpt_timer
// assumes: zero-wait ahb slave; slow tick every 4 core clocks
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic hsel_in = 1'b0;
   logic [31:0] haddr_in = 32'h0;
   logic [1:0] htrans_in = 2'h0;
   logic hwrite_in = 1'b0;
   logic [31:0] hwdata_in = 32'h0;
   logic slow_tick_in = 1'b0;
   logic [1:0] slow_cnt = 2'h0;
   logic ext_in = 1'b1;
   wire logic rdy;
   wire logic resp;
   wire logic pin;
   wire logic irq;
   wire logic [31:0] rdata;
   int n_mismatch = 0;
   int num_checks = 0;
   int t_low;
   int t_irq;

   cpt_timer dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
      .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
      .hwdata_in(hwdata_in), .hready_in(rdy), .hreadyout_out(rdy), .hresp_out(resp),
      .hrdata_out(rdata), .slow_tick_in(slow_tick_in), .external_count_input_in(ext_in),
      .timer_output_pin_out(pin), .cascade_timer_irq_out(irq));

   always #2 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) begin
      slow_cnt <= slow_cnt + 2'h1;
      slow_tick_in <= (slow_cnt == 2'h3);
   end
   ////////////////////////////////////////////////////////////////
   task automatic miss(input string what);
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, what);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) miss($sformatf("value %h, expected %h", got, exp));
   endtask
   task automatic chk_n(input int got, input int exp);
      num_checks++;
      if (got != exp) miss($sformatf("count %0d, expected %0d", got, exp));
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      hsel_in <= 1'b1;
      haddr_in <= {24'h0, a};
      htrans_in <= 2'h2;
      hwrite_in <= w;
      do @(posedge core_clk_in); while (rdy !== 1'b1);
      htrans_in <= 2'h0;
      hwdata_in <= d;
      do @(posedge core_clk_in); while (rdy !== 1'b1);
      q = rdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      xfer(1'b1, a, {24'h0, d}, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   // edges until irq is seen; first edge that sees the pin low
   task automatic span(input int lim);
      t_low = -1;
      t_irq = 0;
      do begin
         @(posedge core_clk_in);
         t_irq++;
         if (pin === 1'b0 && t_low < 0) t_low = t_irq;
      end while (irq !== 1'b1 && t_irq < lim);
   endtask
   task automatic ext_lvl(input logic v, input int n);
      ext_in <= v;
      repeat (n) @(posedge core_clk_in);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk_in);
      miss("watchdog expired");
      complete_run();
   end
   initial begin
      repeat (10) @(posedge core_clk_in);
      rst_in <= 1'b0;
      @(posedge core_clk_in);
      chk({31'h0, pin}, 32'h1);
      for (int i = 0; i < 8; i++) rd_chk(8'(i * 4), 32'h0);
      for (int i = 0; i < 8; i++) begin
         wr(8'h00, {1'b0, 3'(i), 4'h3});
         rd_chk(8'h00, {25'h0, 3'(i), 4'h3});
      end
      wr(8'h04, 8'h57);
      wr(8'h00, 8'h63);
      wr(8'h08, 8'h0A);
      wr(8'h0C, 8'h00);
      wr(8'h10, 8'h04);
      wr(8'h14, 8'h00);
      rd_chk(8'h08, 32'h0000000A);
      wr(8'h04, 8'h5F);
      span(100);
      span(100);
      chk_n(t_low, 4);
      chk_n(t_irq, 10);
      wr(8'h04, 8'h57);
      wr(8'h10, 8'h06);
      wr(8'h14, 8'h00);
      wr(8'h00, 8'h33);
      wr(8'h04, 8'h5F);
      span(100);
      span(100);
      chk_n(t_low, 48);
      chk_n(t_irq, 80);
      repeat (50) @(posedge core_clk_in);
      wr(8'h04, 8'h57);
      repeat (20) @(posedge core_clk_in);
      chk({31'h0, pin}, 32'h0);
      rd_chk(8'h18, 32'h00010000);
      wr(8'h04, 8'h57);
      repeat (2) @(posedge core_clk_in);
      chk({31'h0, pin}, 32'h1);
      wr(8'h04, 8'hD7);
      repeat (2) @(posedge core_clk_in);
      chk({31'h0, pin}, 32'h0);
      wr(8'h04, 8'h57);
      wr(8'h08, 8'h10);
      wr(8'h0C, 8'h00);
      wr(8'h00, 8'h73);
      wr(8'h04, 8'h5F);
      ext_lvl(1'b1, 8);
      repeat (3) begin
         ext_lvl(1'b0, 8);
         ext_lvl(1'b1, 8);
      end
      ext_lvl(1'b0, 3);
      ext_lvl(1'b1, 20);
      rd_chk(8'h18, 32'h00000003);
      wr(8'h04, 8'h57);
      wr(8'h00, 8'h43);
      wr(8'h04, 8'h05);
      wr(8'h08, 8'hFF);
      wr(8'h0C, 8'h01);
      wr(8'h04, 8'h0D);
      span(3000);
      span(3000);
      chk_n(t_irq, 1024);
      chk_n(t_low, -1);
      wr(8'h04, 8'h05);
      complete_run();
   end
endmodule // testbench
`default_nettype wire
